// File: core/brs_regs.svh
// Constants of the bridge status and port timing readback block.
// Assumes inclusion by bare name from the package and the design modules.
// Function
// - Line commands and device reset leave the pointer on status.
// - Status bits change only while certain commands execute, except line level at read addressing on status.
// - Busy bit is 1 during line traffic, 0 once the command is done.
// - Line reset sets presence bit when a presence pulse is sampled.
// - Later line reset clears presence on no pulse or a shorted line.
// - Line reset sets short bit when the line is sampled low.
// - Short bit clears at a later line reset once the short is gone.
// - Short bit set means presence bit reads 0.
// - Line level sampled at read addressing acknowledge, pointer on status only.
// - Reset flag set after power-on or device reset.
// - Write configuration command clears the reset flag.
// - Single bit result captures bit or first triplet bit; 0 after reset.
// - Second bit result captures triplet second bit, only on triplets.
// - Branch bit reports triplet direction, changes only on triplets.
// - Port readback returns a 4-bit code, upper nibble zero.
// - Adjust port command leaves the pointer on port readback.
// - Port reads step through eight timing and pullup entries in order.
// - After the last entry, port reads wrap back to the first.
// - Invalid code or parameter is not acknowledged.
// - Each command sets the pointer to its most relevant register.
// - Set pointer accepts C3h, F0h, E1h, B4h; others ignored, not acknowledged.
// - Device reset sets reset flag, keeps line level, clears all other stored status bits.
`ifndef BRS_REGS_SVH
`define BRS_REGS_SVH
// Status bit positions
`define BRS_ST_BUSY 0
`define BRS_ST_PRES 1
`define BRS_ST_SHORT 2
`define BRS_ST_LEVEL 3
`define BRS_ST_RSTOCC 4
`define BRS_ST_SBR 5
`define BRS_ST_TSB 6
`define BRS_ST_DIR 7
// Read pointer codes
`define BRS_PTR_CFG 8'hc3
`define BRS_PTR_STAT 8'hf0
`define BRS_PTR_DATA 8'he1
`define BRS_PTR_PORT 8'hb4
// Function command codes
`define BRS_CMD_DEV_RST 8'hf0
`define BRS_CMD_SET_PTR 8'he1
`define BRS_CMD_WR_CFG 8'hd2
`define BRS_CMD_ADJ_PORT 8'h16
`define BRS_CMD_LINE_RST 8'h11
`define BRS_CMD_LINE_BIT 8'h12
`define BRS_CMD_LINE_WBYTE 8'h13
`define BRS_CMD_LINE_RBYTE 8'h14
`define BRS_CMD_LINE_TRIP 8'h15
// Port readback table
`define BRS_PORT_ENTRIES 8
`define BRS_PORT_LAST 3'h7
`define BRS_PORT_DEF 4'h6
`define BRS_ADJ_IDX_MAX 3'h4
// Reset values
`define BRS_CFG_RST 4'h0
`define BRS_STAT_RST 8'h10
`endif

// File: core/brs_pkg.sv
// Types shared by the bridge status block.
// Assumes brs_regs.svh is on the include path.
`include "brs_regs.svh"
package brs_pkg;
  typedef enum logic [2:0] {OP_RESET, OP_BIT, OP_WBYTE, OP_RBYTE, OP_TRIP} brs_op_t;
  typedef enum logic [1:0] {PTR_CFG, PTR_STAT, PTR_DATA, PTR_PORT} brs_ptr_t;
  typedef struct packed {
    logic dir;
    logic second_bit_result;
    logic single_bit_result;
    logic rst_occ;
    logic level;
    logic short_seen;
    logic pres;
    logic busy;
  } brs_stat_t;
  typedef struct packed {
    brs_op_t op;
    logic [7:0] param;
  } brs_req_t;
  typedef struct packed {
    brs_op_t op;
    logic pres;
    logic short_seen;
    logic bit1;
    logic bit2;
    logic dir;
    logic [7:0] data;
  } brs_res_t;
endpackage

// File: core/brs_sync.sv
// Single-bit synchroniser, plain two-stage or three-stage with agreement filter.
// Assumes d is asynchronous to clk; q is the settled level.
`timescale 1ns/1ps
module brs_sync #(
  parameter bit FILTER = 1'b0,
  parameter bit RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic d,
  output logic q
);
  logic s1_ff, s2_ff, s3_ff, q_ff;

  // Stage chain; s1 feeds only s2
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Filtered output follows only once two settled stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= RST_VAL;
    end else if (s2_ff == s3_ff) begin
      q_ff <= s3_ff;
    end
  end

  assign q = FILTER ? q_ff : s2_ff;
endmodule // brs_sync

// File: core/brs_status.sv
// Status register, read pointer and port timing readback of the bridge.
// Assumes a host front end delivering decoded command strings and read strobes
// on sys_clk, and a line engine on line_clk reporting one result per start.
`timescale 1ns/1ps
`include "brs_regs.svh"
module brs_status import brs_pkg::*; #(
  parameter int PORT_ENTRIES = `BRS_PORT_ENTRIES
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host command string
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_param,
  output logic cmd_done,
  output logic cmd_ack,
  // Host reads
  input wire logic rd_addr_ack,
  input wire logic rd_req,
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Line pin level
  input wire logic line_pin,
  // Line engine side
  input wire logic line_clk,
  input wire logic line_rst,
  output logic line_go,
  output brs_req_t line_req,
  input wire logic res_valid,
  input wire brs_res_t res_in,
  // Observed state
  output brs_stat_t status,
  output logic [3:0] cfg_nibble
);
  // Table shape is fixed by the readback order
  generate
    if (PORT_ENTRIES != `BRS_PORT_ENTRIES) begin : g_bad_entries
      $error("brs_status: PORT_ENTRIES must be 8");
    end
  endgenerate

  brs_stat_t stat_ff;
  brs_ptr_t ptr_ff, nxt_ptr;
  logic [3:0] cfg_ff;
  logic [7:0] data_ff;
  logic [3:0] port_ff [PORT_ENTRIES];
  logic [2:0] port_idx_ff;
  logic cmd_done_ff, cmd_ack_ff, rd_valid_ff;
  logic [7:0] rd_data_ff;
  logic cmd_ok, is_line, is_dev_rst, is_cfg, is_adj, is_ptr;
  brs_op_t nxt_op;
  logic [2:0] adj_slot;
  logic line_take, dev_rst_take, cfg_take, adj_take, ptr_take;
  logic pin_lvl;
  // Crossing state, sys side
  brs_req_t req_hold_ff;
  logic req_tog_ff, res_tog_sync, res_seen_ff, res_edge, res_take;
  // Crossing state, line side
  logic req_tog_sync, req_seen_ff, line_go_ff;
  brs_req_t line_req_ff;
  brs_res_t res_hold_ff;
  logic res_tog_ff;

  // Line pin into the system domain, filtered
  brs_sync #(.FILTER(1'b1), .RST_VAL(1'b1)) u_pin_sync (
    .clk(sys_clk),
    .rst(rst),
    .d(line_pin),
    .q(pin_lvl)
  );

  // Command decode; unknown codes fall to default and are refused
  always_comb begin
    cmd_ok = 1'b0;
    is_line = 1'b0;
    is_dev_rst = 1'b0;
    is_cfg = 1'b0;
    is_adj = 1'b0;
    is_ptr = 1'b0;
    nxt_op = OP_RESET;
    nxt_ptr = ptr_ff;
    case (cmd_code)
      `BRS_CMD_DEV_RST: begin
        cmd_ok = 1'b1;
        is_dev_rst = 1'b1;
        nxt_ptr = PTR_STAT;
      end
      `BRS_CMD_SET_PTR: begin
        is_ptr = 1'b1;
        cmd_ok = 1'b1;
        case (cmd_param)
          `BRS_PTR_CFG: nxt_ptr = PTR_CFG;
          `BRS_PTR_STAT: nxt_ptr = PTR_STAT;
          `BRS_PTR_DATA: nxt_ptr = PTR_DATA;
          `BRS_PTR_PORT: nxt_ptr = PTR_PORT;
          default: cmd_ok = 1'b0;
        endcase
      end
      `BRS_CMD_WR_CFG: begin
        // Upper nibble must complement lower, and the line must be idle
        cmd_ok = !stat_ff.busy && (cmd_param[7:4] == ~cmd_param[3:0]);
        is_cfg = 1'b1;
        nxt_ptr = PTR_CFG;
      end
      `BRS_CMD_ADJ_PORT: begin
        cmd_ok = (cmd_param[7:5] <= `BRS_ADJ_IDX_MAX);
        is_adj = 1'b1;
        nxt_ptr = PTR_PORT;
      end
      `BRS_CMD_LINE_RST, `BRS_CMD_LINE_BIT, `BRS_CMD_LINE_WBYTE,
      `BRS_CMD_LINE_RBYTE, `BRS_CMD_LINE_TRIP: begin
        cmd_ok = !stat_ff.busy;
        is_line = 1'b1;
        nxt_ptr = PTR_STAT;
        unique case (cmd_code)
          `BRS_CMD_LINE_BIT: nxt_op = OP_BIT;
          `BRS_CMD_LINE_WBYTE: nxt_op = OP_WBYTE;
          `BRS_CMD_LINE_RBYTE: nxt_op = OP_RBYTE;
          `BRS_CMD_LINE_TRIP: nxt_op = OP_TRIP;
          default: nxt_op = OP_RESET;
        endcase
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  assign line_take = cmd_valid && cmd_ok && is_line;
  assign dev_rst_take = cmd_valid && cmd_ok && is_dev_rst;
  assign cfg_take = cmd_valid && cmd_ok && is_cfg;
  assign adj_take = cmd_valid && cmd_ok && is_adj;
  assign ptr_take = cmd_valid && cmd_ok && is_ptr;
  // Slot of the adjusted entry: paired speeds first, then single entries
  assign adj_slot = (cmd_param[7:5] < 3'h3) ? {cmd_param[6:5], cmd_param[4]} :
                    (cmd_param[7:5] + 3'h3);

  // Acknowledge answer, one cycle after the string
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_done_ff <= 1'b0;
      cmd_ack_ff <= 1'b0;
    end else begin
      cmd_done_ff <= cmd_valid;
      cmd_ack_ff <= cmd_valid && cmd_ok;
    end
  end

  // Read pointer; a refused string leaves it alone
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr_ff <= PTR_STAT;
    end else if (cmd_valid && cmd_ok) begin
      ptr_ff <= nxt_ptr;
    end
  end

  // Configuration nibble, kept only for readback here
  always_ff @(posedge sys_clk) begin
    if (rst || dev_rst_take) begin
      cfg_ff <= `BRS_CFG_RST;
    end else if (cfg_take) begin
      cfg_ff <= cmd_param[3:0];
    end
  end

  // Port timing table; device reset restores the defaults
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < PORT_ENTRIES; i++) begin
      if (rst || dev_rst_take) begin
        port_ff[i] <= `BRS_PORT_DEF;
      end else if (adj_take && (adj_slot == 3'(i))) begin
        port_ff[i] <= cmd_param[3:0];
      end
    end
  end

  // Readback position; restarts at entry 0 when the table is adjusted
  always_ff @(posedge sys_clk) begin
    if (rst || dev_rst_take || adj_take) begin
      port_idx_ff <= 3'h0;
    end else if (rd_req && ptr_ff == PTR_PORT) begin
      port_idx_ff <= (port_idx_ff == `BRS_PORT_LAST) ? 3'h0 : port_idx_ff + 3'h1;
    end
  end

  // Status register; only command effects, results and read addressing on status touch it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_ff <= brs_stat_t'(`BRS_STAT_RST);
    end else if (dev_rst_take) begin
      stat_ff <= brs_stat_t'(`BRS_STAT_RST) | {4'h0, stat_ff.level, 3'h0};
    end else begin
      if (line_take) begin
        stat_ff.busy <= 1'b1;
      end else if (res_take) begin
        stat_ff.busy <= 1'b0;
        unique case (res_hold_ff.op)
          OP_RESET: begin
            stat_ff.short_seen <= res_hold_ff.short_seen;
            stat_ff.pres <= res_hold_ff.pres && !res_hold_ff.short_seen;
          end
          OP_BIT: stat_ff.single_bit_result <= res_hold_ff.bit1;
          OP_TRIP: begin
            stat_ff.single_bit_result <= res_hold_ff.bit1;
            stat_ff.second_bit_result <= res_hold_ff.bit2;
            stat_ff.dir <= res_hold_ff.dir;
          end
          OP_WBYTE, OP_RBYTE: begin
          end
        endcase
      end
      if (cfg_take) begin
        stat_ff.rst_occ <= 1'b0;
      end
      if (rd_addr_ack && ptr_ff == PTR_STAT) begin
        stat_ff.level <= pin_lvl;
      end
    end
  end

  // Read data register, loaded by a read byte result
  always_ff @(posedge sys_clk) begin
    if (rst || dev_rst_take) begin
      data_ff <= 8'h00;
    end else if (res_take && res_hold_ff.op == OP_RBYTE) begin
      data_ff <= res_hold_ff.data;
    end
  end

  // Read mux; the pointer stays put on every data read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      rd_valid_ff <= rd_req;
      if (rd_req) begin
        unique case (ptr_ff)
          PTR_CFG: rd_data_ff <= {4'h0, cfg_ff};
          PTR_STAT: rd_data_ff <= stat_ff;
          PTR_DATA: rd_data_ff <= data_ff;
          PTR_PORT: rd_data_ff <= {4'h0, port_ff[port_idx_ff]};
        endcase
      end
    end
  end

  // Request crossing: word loads on the same edge the toggle flips, then is held stable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_hold_ff <= '0;
      req_tog_ff <= 1'b0;
    end else if (line_take) begin
      req_hold_ff <= '{op: nxt_op, param: cmd_param};
      req_tog_ff <= ~req_tog_ff;
    end
  end

  // Result toggle back into the system domain
  brs_sync #(.FILTER(1'b1)) u_res_sync (
    .clk(sys_clk),
    .rst(rst),
    .d(res_tog_ff),
    .q(res_tog_sync)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_seen_ff <= 1'b0;
    end else begin
      res_seen_ff <= res_tog_sync;
    end
  end

  assign res_edge = res_tog_sync ^ res_seen_ff;
  // A result after a device reset abort finds busy low and is dropped
  assign res_take = res_edge && stat_ff.busy;

  // Line domain: request toggle in
  brs_sync #(.FILTER(1'b1)) u_req_sync (
    .clk(line_clk),
    .rst(line_rst),
    .d(req_tog_ff),
    .q(req_tog_sync)
  );

  // Start pulse and request word toward the engine
  always_ff @(posedge line_clk) begin
    if (line_rst) begin
      req_seen_ff <= 1'b0;
      line_go_ff <= 1'b0;
      line_req_ff <= '0;
    end else begin
      req_seen_ff <= req_tog_sync;
      line_go_ff <= req_tog_sync ^ req_seen_ff;
      if (req_tog_sync ^ req_seen_ff) begin
        line_req_ff <= req_hold_ff;
      end
    end
  end

  // Result capture; engine holds off its next result until the next start
  always_ff @(posedge line_clk) begin
    if (line_rst) begin
      res_hold_ff <= '0;
      res_tog_ff <= 1'b0;
    end else if (res_valid) begin
      res_hold_ff <= res_in;
      res_tog_ff <= ~res_tog_ff;
    end
  end

  assign cmd_done = cmd_done_ff;
  assign cmd_ack = cmd_ack_ff;
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;
  assign line_go = line_go_ff;
  assign line_req = line_req_ff;
  assign status = stat_ff;
  assign cfg_nibble = cfg_ff;

  // Checks
  sequence s_stat_read;
    rd_req && ptr_ff == PTR_STAT && !cmd_valid;
  endsequence
  sequence s_port_last;
    rd_req && ptr_ff == PTR_PORT && port_idx_ff == `BRS_PORT_LAST && !cmd_valid;
  endsequence
  ptr_after_line_a: assert property (@(posedge sys_clk) disable iff (rst)
    (line_take || dev_rst_take) |=> ptr_ff == PTR_STAT)
    else $error("pointer not on status after line or reset command");
  status_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(line_take || dev_rst_take || cfg_take || res_take || rd_addr_ack)
    |=> $stable(stat_ff))
    else $error("status changed without a command");
  busy_span_a: assert property (@(posedge sys_clk) disable iff (rst)
    line_take |=> stat_ff.busy throughout (!res_take && !dev_rst_take)[*1])
    else $error("busy not held after line command");
  busy_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    res_take && !line_take && !dev_rst_take |=> !stat_ff.busy)
    else $error("busy not cleared on result");
  short_excl_a: assert property (@(posedge sys_clk) disable iff (rst)
    stat_ff.short_seen |-> !stat_ff.pres)
    else $error("presence set while short seen");
  level_sample_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_addr_ack && ptr_ff == PTR_STAT && !dev_rst_take |=> stat_ff.level == $past(pin_lvl))
    else $error("line level not sampled");
  dev_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    dev_rst_take |=> stat_ff.rst_occ && (stat_ff & 8'he7) == 8'h00)
    else $error("device reset left status bits");
  cfg_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    cfg_take |=> !stat_ff.rst_occ)
    else $error("reset flag not cleared by configuration write");
  port_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_port_last |=> port_idx_ff == 3'h0)
    else $error("port readback did not wrap");
  port_upper_a: assert property (@(posedge sys_clk) disable iff (rst)
    rd_req && ptr_ff == PTR_PORT |=> rd_valid_ff && rd_data_ff[7:4] == 4'h0)
    else $error("port readback upper nibble not zero");
  stat_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_stat_read |=> rd_valid_ff && rd_data_ff == $past(stat_ff) && ptr_ff == PTR_STAT)
    else $error("status read moved pointer or returned stale data");
  refuse_ptr_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_valid && is_ptr && !cmd_ok |=> cmd_done_ff && !cmd_ack_ff && $stable(ptr_ff))
    else $error("bad pointer code accepted");
  line_start_a: assert property (@(posedge line_clk) disable iff (line_rst)
    $rose(req_tog_sync) || $fell(req_tog_sync) |=> line_go_ff ##1 !line_go_ff)
    else $error("line start pulse missing");
endmodule // brs_status

// File: bench/brs_engine.sv
// Line engine model standing behind the status block's line side.
// Assumes a free-running line_clk; result fields come from the bench.
`timescale 1ns/1ps
module brs_engine import brs_pkg::*; (
  // Link clock and reset
  input wire logic line_clk,
  input wire logic line_rst,
  // Start from the block
  input wire logic line_go,
  input wire brs_req_t line_req,
  // Result to the block
  output logic res_valid,
  output brs_res_t res_in,
  // Result fields set by the bench
  input wire logic pres,
  input wire logic short_seen,
  input wire logic bit1,
  input wire logic bit2,
  input wire logic dir,
  input wire logic [7:0] data,
  input wire logic slow
);
  logic run_ff;
  logic [5:0] cnt_ff;
  brs_op_t op_ff;
  // One result per start, after a short or a long line slot
  always_ff @(posedge line_clk) begin
    if (line_rst) begin
      run_ff <= 1'b0;
      cnt_ff <= 6'h0;
      op_ff <= OP_RESET;
      res_valid <= 1'b0;
      res_in <= '0;
    end else begin
      res_valid <= 1'b0;
      res_in <= brs_res_t'(~res_in); // Stale fields toggle so no old value lingers
      if (line_go) begin
        run_ff <= 1'b1;
        op_ff <= line_req.op;
        cnt_ff <= slow ? 6'h1e : 6'h02;
      end else if (run_ff) begin
        if (cnt_ff == 6'h0) begin
          run_ff <= 1'b0;
          res_valid <= 1'b1;
          res_in <= '{op_ff, pres, short_seen, bit1, bit2, dir, data};
        end else begin
          cnt_ff <= cnt_ff - 6'h1;
        end
      end
    end
  end
endmodule // brs_engine

// File: bench/brs_status_tb.sv
// Self-checking bench of the status, pointer and port readback block.
// Assumes brs_pkg compiled first and brs_regs.svh on the include path.
`timescale 1ns/1ps
`include "brs_regs.svh"
module brs_status_tb;
  import brs_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, line_clk = 1'b0, line_rst = 1'b1;
  logic cmd_valid = 1'b0, rd_addr_ack = 1'b0, rd_req = 1'b0, line_pin = 1'b1;
  logic [7:0] cmd_code = 8'h0, cmd_param = 8'h0, e_data = 8'h0;
  logic e_pres = 1'b0, e_short = 1'b0, e_b1 = 1'b0, e_b2 = 1'b0, e_dir = 1'b0;
  logic e_slow = 1'b0;
  logic cmd_done, cmd_ack, rd_valid, line_go, res_valid;
  logic [7:0] rd_data;
  logic [3:0] cfg_nibble;
  brs_req_t line_req;
  brs_res_t res_in;
  brs_stat_t status;
  int n_fail = 0, comparisons = 0;
  logic [7:0] ptr_codes [4] = '{8'hc3, 8'hf0, 8'he1, 8'hb4};

  brs_status #(.PORT_ENTRIES(8)) uut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_param(cmd_param), .cmd_done(cmd_done), .cmd_ack(cmd_ack),
    .rd_addr_ack(rd_addr_ack), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
    .line_pin(line_pin), .line_clk(line_clk), .line_rst(line_rst), .line_go(line_go),
    .line_req(line_req), .res_valid(res_valid), .res_in(res_in), .status(status),
    .cfg_nibble(cfg_nibble));
  brs_engine eng (.line_clk(line_clk), .line_rst(line_rst), .line_go(line_go),
    .line_req(line_req), .res_valid(res_valid), .res_in(res_in), .pres(e_pres),
    .short_seen(e_short), .bit1(e_b1), .bit2(e_b2), .dir(e_dir), .data(e_data),
    .slow(e_slow));

  // Clocks, the link one with an unrelated phase
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #3;
    forever #40 line_clk = ~line_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One host string, then its done and acknowledge
  task automatic cmd(input logic [7:0] c, input logic [7:0] p, input logic a);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_param <= p;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    chk("cmd_done", 8'h01, {7'h0, cmd_done});
    chk("cmd_ack", {7'h0, a}, {7'h0, cmd_ack});
  endtask
  task automatic rd(input logic [7:0] e);
    @(posedge sys_clk);
    rd_req <= 1'b1;
    @(posedge sys_clk);
    rd_req <= 1'b0;
    #1;
    chk("rd_valid", 8'h01, {7'h0, rd_valid});
    chk("rd_data", e, rd_data);
  endtask
  // Read addressing, which samples the line when pointing at status
  task automatic addr();
    @(posedge sys_clk);
    rd_addr_ack <= 1'b1;
    @(posedge sys_clk);
    rd_addr_ack <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // Line command: busy while the engine works, then the settled status
  task automatic lcmd(input logic [7:0] c, input logic [7:0] e);
    int n;
    n = 0;
    cmd(c, 8'h00, 1'b1);
    chk("busy", 8'h01, {7'h0, status.busy});
    while (status.busy !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    #1;
    chk("status", e, status);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly one thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (12) @(posedge sys_clk);
    line_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'h10);
    rd(8'h10);
    e_pres <= 1'b1;
    e_slow <= 1'b1;
    lcmd(`BRS_CMD_LINE_RST, 8'h12);
    e_slow <= 1'b0;
    rd(8'h12);
    e_short <= 1'b1;
    lcmd(`BRS_CMD_LINE_RST, 8'h14);
    e_short <= 1'b0;
    e_pres <= 1'b0;
    lcmd(`BRS_CMD_LINE_RST, 8'h10);
    e_pres <= 1'b1;
    cmd(`BRS_CMD_LINE_RST, 8'h00, 1'b1);
    cmd(`BRS_CMD_LINE_BIT, 8'h80, 1'b0);
    repeat (150) @(posedge sys_clk);
    chk("status", 8'h12, status);
    e_b1 <= 1'b1;
    lcmd(`BRS_CMD_LINE_BIT, 8'h32);
    e_b1 <= 1'b0;
    e_b2 <= 1'b1;
    e_dir <= 1'b1;
    lcmd(`BRS_CMD_LINE_TRIP, 8'hd2);
    e_data <= 8'h5a;
    lcmd(`BRS_CMD_LINE_WBYTE, 8'hd2);
    lcmd(`BRS_CMD_LINE_RBYTE, 8'hd2);
    rd(8'hd2);
    cmd(`BRS_CMD_SET_PTR, `BRS_PTR_DATA, 1'b1);
    rd(8'h5a);
    cmd(`BRS_CMD_WR_CFG, 8'h11, 1'b0);
    cmd(`BRS_CMD_WR_CFG, 8'he1, 1'b1);
    chk("status", 8'hc2, status);
    chk("cfg_nibble", 8'h01, {4'h0, cfg_nibble});
    rd(8'h01);
    // Every pointer code, then one that is not on the list
    foreach (ptr_codes[i]) begin
      cmd(`BRS_CMD_SET_PTR, ptr_codes[i], 1'b1);
    end
    cmd(`BRS_CMD_SET_PTR, 8'h55, 1'b0);
    cmd(`BRS_CMD_ADJ_PORT, 8'ha3, 1'b0);
    cmd(`BRS_CMD_ADJ_PORT, 8'h2a, 1'b1);
    // Overdrive half of a pair and a single entry land in their own slots
    cmd(`BRS_CMD_ADJ_PORT, 8'h3c, 1'b1);
    cmd(`BRS_CMD_ADJ_PORT, 8'h83, 1'b1);
    for (int i = 0; i < 11; i++) begin
      rd((i % 8 == 2) ? 8'h0a : (i % 8 == 3) ? 8'h0c : (i % 8 == 7) ? 8'h03 : 8'h06);
    end
    // Line level only follows the pin when the pointer is on status
    cmd(`BRS_CMD_SET_PTR, `BRS_PTR_STAT, 1'b1);
    addr();
    chk("status", 8'hca, status);
    line_pin <= 1'b0;
    cmd(`BRS_CMD_SET_PTR, `BRS_PTR_PORT, 1'b1);
    repeat (6) @(posedge sys_clk);
    addr();
    chk("status", 8'hca, status);
    cmd(`BRS_CMD_DEV_RST, 8'h00, 1'b1);
    chk("status", 8'h18, status);
    rd(8'h18);
    tally_and_finish();
  end
endmodule // brs_status_tb
